// File: logic/pom_mux.sv
// Port 1 output override multiplexer with its regulator configuration register
//
// Functional notes
// R1: Pin 6 enable routes selected source out
// R2: Pin 6 select: timer or 32k clock
// R3: Pin 4 select: relaxation osc or comparator1
// R4: Pin 4 enable routes selected source out
// R5: Pin 2 select: system clock or touch signal
// R6: Pin 2 enable routes selected source out
// R7: Pin 0 select: sleep tick or comparator0
// R8: Pin 0 enable routes selected source out
// R9: Enabled override beats other pin functions
// R10: Software sets drive modes before overriding
// R11: Software picks pump clock by system clock rate
// R12: Three-bit level field picks regulator level
// R13: Software writes zero to reserved bits
// R14: Reset clears every enable and select
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module pom_mux
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       timer_output,
  input  wire logic       slow_32k_clock,
  input  wire logic       relax_osc_out,
  input  wire logic       comparator1_output,
  input  wire logic       comparator0_output,
  input  wire logic       sleep_interrupt_tick,
  input  wire logic       main_system_clock,
  input  wire logic       touch_sense_output,
  input  wire logic       touch_sense_clock,
  input  wire logic       touch_clock_pick,
  input  wire logic [7:0] port1_func_data,
  input  wire logic [7:0] port1_func_oe,
  output logic      [7:0] port1_out,
  output logic      [7:0] port1_oe,
  output logic      [2:0] regulator_level,
  output logic      [1:0] pump_clock_sel
);
  import pom_pkg::*;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] ovr_reg;
  logic [7:0] ovr_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // A write strobe aimed at one register offset
  function automatic logic write_hits
  (
    input logic       wr,
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    return wr && (addr == offset);
  endfunction

  always_comb
  begin
    ovr_next   = ovr_reg;
    cfg_next   = cfg_reg;
    rdata_next = 8'h00;
    if (write_hits(reg_wr, reg_addr, OVR_OFFSET))
    begin
      ovr_next = reg_wdata;
    end
    // R12: level field stored
    if (write_hits(reg_wr, reg_addr, REGCFG_OFFSET))
    begin
      cfg_next = reg_wdata & REGCFG_MASK;
    end
    if (reg_rd)
    begin
      case (reg_addr)
        OVR_OFFSET:    rdata_next = ovr_reg;
        REGCFG_OFFSET: rdata_next = cfg_reg;
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  // R14: cleared at reset
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ovr_reg   <= OVR_RESET;
      cfg_reg   <= REGCFG_RESET;
      rdata_reg <= 8'h00;
    end
    else
    begin
      ovr_reg   <= ovr_next;
      cfg_reg   <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // Pin multiplexer
  // ************************************************************
  // Outputs are registered, so each pin lags its source by one mclk;
  // clocks faster than mclk/2 cannot be passed faithfully.
  logic [7:0] pout_reg;
  logic [7:0] pout_next;
  logic [7:0] poe_reg;
  logic [7:0] poe_next;
  logic [3:0] ovr_en;
  logic [3:0] ovr_val;

  always_comb
  begin
    ovr_en  = {ovr_reg[P6_EN_BIT], ovr_reg[P4_EN_BIT],
               ovr_reg[P2_EN_BIT], ovr_reg[P0_EN_BIT]};
    // R7: pin 0 source
    ovr_val[0] = ovr_reg[P0_SEL_BIT] ? comparator0_output : sleep_interrupt_tick;
    // R5: pin 2 source
    ovr_val[1] = ovr_reg[P2_SEL_BIT]
               ? (touch_clock_pick ? touch_sense_clock : touch_sense_output)
               : main_system_clock;
    // R3: pin 4 source
    ovr_val[2] = ovr_reg[P4_SEL_BIT] ? comparator1_output : relax_osc_out;
    // R2: pin 6 source
    ovr_val[3] = ovr_reg[P6_SEL_BIT] ? slow_32k_clock : timer_output;
    pout_next  = port1_func_data;
    poe_next   = port1_func_oe;
    // R1: R4: R6: R8: enables gate override
    // R9: override wins over function
    for (int i = 0; i < 4; i++)
    begin
      if (ovr_en[i])
      begin
        pout_next[2*i] = ovr_val[i];
        poe_next[2*i]  = 1'h1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pout_reg <= 8'h00;
      poe_reg  <= 8'h00;
    end
    else
    begin
      pout_reg <= pout_next;
      poe_reg  <= poe_next;
    end
  end

  assign port1_out       = pout_reg;
  assign port1_oe        = poe_reg;
  assign reg_rdata       = rdata_reg;
  assign regulator_level = cfg_reg[LEVEL_MSB:LEVEL_LSB];
  assign pump_clock_sel  = cfg_reg[PUMP_MSB:PUMP_LSB];

  // ************************************************************
  // Checks
  // ************************************************************
  // Pin 6: timer output or slow clock; pins show reset values in the cycle after reset
  chk_pin6_timer: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    !$past(sys_rst) && $past(ovr_reg[P6_EN_BIT]) && !$past(ovr_reg[P6_SEL_BIT])
    |-> port1_out[6] == $past(timer_output))
    else $error("pin 6 timer select wrong");
  chk_pin6_slowclk: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    !$past(sys_rst) && $past(ovr_reg[P6_EN_BIT]) && $past(ovr_reg[P6_SEL_BIT])
    |-> port1_out[6] == $past(slow_32k_clock))
    else $error("pin 6 slow clock select wrong");
  chk_pin6_route: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    !$past(sys_rst) && $past(ovr_reg[P6_EN_BIT])
    |-> port1_oe[6])
    else $error("pin 6 override not driven");
  chk_pin6_off_data: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    !$past(sys_rst) && !$past(ovr_reg[P6_EN_BIT])
    |-> port1_out[6] == $past(port1_func_data[6]))
    else $error("pin 6 override data leaked");
  chk_pin6_off_oe: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    !$past(sys_rst) && !$past(ovr_reg[P6_EN_BIT])
    |-> port1_oe[6] == $past(port1_func_oe[6]))
    else $error("pin 6 override enable leaked");

  // Pin 4: relaxation oscillator or comparator 1
  chk_pin4_relax: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    !$past(sys_rst) && $past(ovr_reg[P4_EN_BIT]) && !$past(ovr_reg[P4_SEL_BIT])
    |-> port1_out[4] == $past(relax_osc_out))
    else $error("pin 4 oscillator select wrong");
  chk_pin4_src: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    !$past(sys_rst) && $past(ovr_reg[P4_EN_BIT]) && $past(ovr_reg[P4_SEL_BIT])
    |-> port1_out[4] == $past(comparator1_output))
    else $error("pin 4 comparator select wrong");
  chk_pin4_drive: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    !$past(sys_rst) && $past(ovr_reg[P4_EN_BIT])
    |-> port1_oe[4])
    else $error("pin 4 override not driven");
  chk_pin4_off: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    !$past(sys_rst) && !$past(ovr_reg[P4_EN_BIT])
    |-> port1_oe[4] == $past(port1_func_oe[4]))
    else $error("pin 4 override leaked");
  chk_pin4_off_data: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    !$past(sys_rst) && !$past(ovr_reg[P4_EN_BIT])
    |-> port1_out[4] == $past(port1_func_data[4]))
    else $error("pin 4 override data leaked");

  // Pin 2: system clock, or a touch-sense signal picked inside this block by touch_clock_pick
  chk_pin2_src: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    !$past(sys_rst) && $past(ovr_reg[P2_EN_BIT]) && !$past(ovr_reg[P2_SEL_BIT])
    |-> port1_out[2] == $past(main_system_clock))
    else $error("pin 2 system clock select wrong");
  chk_pin2_touch_out: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    !$past(sys_rst) && $past(ovr_reg[P2_EN_BIT]) && $past(ovr_reg[P2_SEL_BIT])
      && !$past(touch_clock_pick)
    |-> port1_out[2] == $past(touch_sense_output))
    else $error("pin 2 touch output select wrong");
  chk_pin2_touch_clk: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    !$past(sys_rst) && $past(ovr_reg[P2_EN_BIT]) && $past(ovr_reg[P2_SEL_BIT])
      && $past(touch_clock_pick)
    |-> port1_out[2] == $past(touch_sense_clock))
    else $error("pin 2 touch clock select wrong");
  chk_pin2_drive: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    !$past(sys_rst) && $past(ovr_reg[P2_EN_BIT])
    |-> port1_oe[2])
    else $error("pin 2 override not driven");
  chk_pin2_off: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    !$past(sys_rst) && !$past(ovr_reg[P2_EN_BIT])
    |-> port1_out[2] == $past(port1_func_data[2]))
    else $error("pin 2 override leaked");
  chk_pin2_off_oe: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    !$past(sys_rst) && !$past(ovr_reg[P2_EN_BIT])
    |-> port1_oe[2] == $past(port1_func_oe[2]))
    else $error("pin 2 override enable leaked");

  // Pin 0: sleep tick or comparator 0
  chk_pin0_sleep: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    !$past(sys_rst) && $past(ovr_reg[P0_EN_BIT]) && !$past(ovr_reg[P0_SEL_BIT])
    |-> port1_out[0] == $past(sleep_interrupt_tick))
    else $error("pin 0 sleep tick select wrong");
  chk_pin0_src: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    !$past(sys_rst) && $past(ovr_reg[P0_EN_BIT]) && $past(ovr_reg[P0_SEL_BIT])
    |-> port1_out[0] == $past(comparator0_output))
    else $error("pin 0 comparator select wrong");
  chk_pin0_drive: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    !$past(sys_rst) && $past(ovr_reg[P0_EN_BIT])
    |-> port1_oe[0])
    else $error("pin 0 override not driven");
  chk_pin0_off: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    !$past(sys_rst) && !$past(ovr_reg[P0_EN_BIT])
    |-> port1_oe[0] == $past(port1_func_oe[0]))
    else $error("pin 0 override leaked");
  chk_pin0_off_data: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    !$past(sys_rst) && !$past(ovr_reg[P0_EN_BIT])
    |-> port1_out[0] == $past(port1_func_data[0]))
    else $error("pin 0 override data leaked");

  // Precedence over other functions; odd pins are never touched
  chk_odd_pass: assert property (@(posedge mclk) disable iff (sys_rst) // R9
    !$past(sys_rst)
    |-> port1_out[1] == $past(port1_func_data[1]) && port1_out[3] == $past(port1_func_data[3])
      && port1_out[5] == $past(port1_func_data[5]) && port1_out[7] == $past(port1_func_data[7])
      && port1_oe[1] == $past(port1_func_oe[1]) && port1_oe[3] == $past(port1_func_oe[3])
      && port1_oe[5] == $past(port1_func_oe[5]) && port1_oe[7] == $past(port1_func_oe[7]))
    else $error("odd pin disturbed");
  chk_ovr_wins: assert property (@(posedge mclk) disable iff (sys_rst) // R9
    !$past(sys_rst) && $past(ovr_reg[P2_EN_BIT]) && !$past(ovr_reg[P2_SEL_BIT])
      && $past(port1_func_oe[2]) && $past(port1_func_data[2]) != $past(main_system_clock)
    |-> port1_out[2] != $past(port1_func_data[2]))
    else $error("pin 2 function beat the override");

  // Register writes, read-back and reset
  chk_level_write: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    reg_wr && reg_addr == REGCFG_OFFSET
    |=> regulator_level == $past(reg_wdata[LEVEL_MSB:LEVEL_LSB]))
    else $error("level field not written");
  chk_pump_write: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    reg_wr && reg_addr == REGCFG_OFFSET
    |=> pump_clock_sel == $past(reg_wdata[PUMP_MSB:PUMP_LSB]))
    else $error("pump clock field not written");
  chk_cfg_reserved: assert property (@(posedge mclk) disable iff (sys_rst) // R13
    reg_rd && reg_addr == REGCFG_OFFSET
    |=> (reg_rdata & ~REGCFG_MASK) == 8'h00)
    else $error("reserved regulator bits read nonzero");
  chk_ovr_write: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    reg_wr && reg_addr == OVR_OFFSET
    |=> ovr_reg == $past(reg_wdata))
    else $error("override register not written");
  chk_ovr_hold: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    !(reg_wr && reg_addr == OVR_OFFSET)
    |=> ovr_reg == $past(ovr_reg))
    else $error("override register changed without a write");
  chk_read_ovr: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    reg_rd && reg_addr == OVR_OFFSET
    |=> reg_rdata == $past(ovr_reg))
    else $error("override read-back wrong");
  chk_read_cfg: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    reg_rd && reg_addr == REGCFG_OFFSET
    |=> reg_rdata == $past(cfg_reg))
    else $error("regulator read-back wrong");
  chk_rdata_idle: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    !reg_rd
    |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_reset_clear: assert property (@(posedge mclk) // R14
    sys_rst
    |=> ovr_reg == OVR_RESET && cfg_reg == REGCFG_RESET
      && port1_out == 8'h00 && port1_oe == 8'h00 && reg_rdata == 8'h00)
    else $error("override not cleared by reset");
endmodule

// File: pkg/pom_pkg.sv
// Register map, field positions and reset values for the port 1 override mux
package pom_pkg;
  localparam logic [7:0] OVR_OFFSET       = 8'hDD;
  localparam logic [7:0] REGCFG_OFFSET    = 8'hDE;
  localparam logic [7:0] OVR_RESET        = 8'h00;
  localparam logic [7:0] REGCFG_RESET     = 8'h00;
  // Reserved bits 7:6 and 2 of the regulator register read as zero
  localparam logic [7:0] REGCFG_MASK      = 8'h3B;
  localparam int         P0_EN_BIT        = 0;
  localparam int         P0_SEL_BIT       = 1;
  localparam int         P2_EN_BIT        = 2;
  localparam int         P2_SEL_BIT       = 3;
  localparam int         P4_EN_BIT        = 4;
  localparam int         P4_SEL_BIT       = 5;
  localparam int         P6_EN_BIT        = 6;
  localparam int         P6_SEL_BIT       = 7;
  localparam int         LEVEL_LSB        = 3;
  localparam int         LEVEL_MSB        = 5;
  localparam int         PUMP_LSB         = 0;
  localparam int         PUMP_MSB         = 1;
endpackage

// File: verif/pom_board.sv
// Board-side model of the port 1 pins
`timescale 1ns/1ps
module pom_board
(
  input  wire logic [7:0] pin_data,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_level
);
  // Undriven pins settle to the board pull-up, never to a stale value
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_level[i] = pin_oe[i] ? pin_data[i] : 1'b1;
  end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the port 1 override mux
`timescale 1ns/1ps
module testbench;
  import pom_pkg::*;
  logic       mclk      = 1'b0;
  logic       sys_rst   = 1'b1;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] func_data = 8'hA5;
  // drive modes of pins 0 to 3 set up
  logic [7:0] func_oe   = 8'h0F;
  logic [9:0] src       = 10'h065;
  logic [7:0] rdata, pout, poe, pin;
  logic [2:0] lvl;
  logic [1:0] pump;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cycles = 0;
  pom_mux dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .timer_output(src[0]),
    .slow_32k_clock(src[1]), .relax_osc_out(src[2]), .comparator1_output(src[3]),
    .comparator0_output(src[4]), .sleep_interrupt_tick(src[5]), .main_system_clock(src[6]),
    .touch_sense_output(src[7]), .touch_sense_clock(src[8]), .touch_clock_pick(src[9]),
    .port1_func_data(func_data), .port1_func_oe(func_oe), .port1_out(pout),
    .port1_oe(poe), .regulator_level(lvl), .pump_clock_sel(pump));
  pom_board board (.pin_data(pout), .pin_oe(poe), .pin_level(pin));
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard: the tests need under a hundred cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 cmp("reg_rdata", exp, rdata);
  endtask
  // Pins lag their sources by one registered edge; the task waits two edges before sampling
  task pins(input logic [7:0] eo, input logic [7:0] ee);
    repeat (2) @(posedge mclk);
    #1 cmp("port1_out", eo, pout);
    cmp("port1_oe", ee, poe);
    cmp("pin_level", eo | ~ee, pin);
  endtask
  task t_reset;
    rd(OVR_OFFSET, OVR_RESET);
    rd(REGCFG_OFFSET, REGCFG_RESET);
    pins(8'hA5, 8'h0F);
    $display("test reset done");
  endtask
  task t_route(input logic [7:0] fd, input logic [9:0] s, input logic [7:0] ovr,
               input logic [7:0] eo, input logic [7:0] ee);
    @(posedge mclk);
    func_data <= fd;
    src <= s;
    wr(OVR_OFFSET, ovr);
    pins(eo, ee);
    rd(OVR_OFFSET, ovr);
    $display("test route %h done", ovr);
  endtask
  task t_regcfg;
    for (int i = 0; i < 8; i++)
    begin
      wr(REGCFG_OFFSET, {2'h0, 3'(i), 1'h0, i[0] ? 2'h2 : 2'h1});
      rd(REGCFG_OFFSET, {2'h0, 3'(i), 1'h0, i[0] ? 2'h2 : 2'h1});
      cmp("regulator_level", {5'h00, 3'(i)}, {5'h00, lvl});
      cmp("pump_clock_sel", i[0] ? 8'h02 : 8'h01, {6'h00, pump});
    end
    wr(REGCFG_OFFSET, 8'hFF);
    rd(REGCFG_OFFSET, REGCFG_MASK);
    wr(8'hDF, 8'hFF);
    rd(8'hDF, 8'h00);
    rd(OVR_OFFSET, 8'hAA);
    $display("test regcfg done");
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_route(8'h00, 10'h065, 8'h55, 8'h55, 8'h5F);
    t_route(8'hFF, 10'h2E5, 8'hFF, 8'hAA, 8'h5F);
    t_route(8'h00, 10'h080, 8'h0C, 8'h04, 8'h0F);
    t_route(8'hA5, 10'h2E5, 8'hAA, 8'hA5, 8'h0F);
    t_regcfg();
    print_verdict();
  end
endmodule
